// file: src/rrs_pkg.sv
// Package with register map, field layout, reset values and timing constants of the relay reset block.
package rrs_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CMD_RST_BIT = 0;
   localparam int CMD_SLEEP_BIT = 1;
   localparam int ST_TER_BIT = 0;
   localparam int ST_LIMP_BIT = 1;
   localparam int ST_UV_BIT = 2;
   localparam int ST_MODE_LSB = 3;
   localparam int ST_CH_LSB = 8;
   localparam int EV_RESET_BIT = 0;
   localparam int EV_LIMP_BIT = 1;
   localparam int EV_WAKE_BIT = 2;
   localparam int EV_UV_BIT = 3;
   localparam int LIMP_CH_A = 4;
   localparam int LIMP_CH_B = 5;
   // ---------------------------------------------------------------
   // Selector codes and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_IN_A = 2'h1;
   localparam logic [1:0] SEL_IN_B = 2'h2;
   localparam logic [1:0] SEL_ON = 2'h3;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [3:0] IRQ_RST = 4'h0;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int UV_DELAY_NS = 1000;
   localparam int UV_DELAY_CYC = UV_DELAY_NS / CLK_NS;
   localparam int WAKE_US = 200;
   localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
   localparam int SYNC_CYC = 3;
   // ---------------------------------------------------------------
   // Operating modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_WAKE,
      MODE_ACTIVE,
      MODE_LIMP
   } rrs_mode_t;
endpackage : rrs_pkg

// file: src/rrs_top.sv
// Reset gathering, serial access guard and channel input selection of the eight channel relay switch.
// Operation
// RQ1: Any reset turns every channel off and restores register defaults.
// RQ2: Every reset of any origin sets the transmission error flag.
// RQ3: During undervoltage reset every read returns the diagnostic frame with error flag.
// RQ4: Undervoltage reset holds until all supplies are above threshold.
// RQ5: Undervoltage reset asserts within 1 us of a supply dropping low.
// RQ6: Writing the command reset bit as one clears all registers at once.
// RQ7: Entering limp home resets all writable registers.
// RQ8: In limp home reads keep working, showing limp status and flags.
// RQ9: In limp home every received command is ignored until it ends.
// RQ10: Per channel selector picks off, input a, input b or on.
// RQ11: An unconnected input pin reads low, so following channels switch off.
// RQ12: After wake-up the device is fully operational within 200 us.
// RQ13: High limp home input enters limp home, waking from sleep.
// RQ14: In limp home inputs a and b drive channels 4 and 5 directly.
// RQ15: Leaving limp home always enters sleep mode.
// RQ16: A followed pin high acts as on, low as off.
// RQ17: Selector codes are 00 off, 01 input a, 10 input b, 11 on.
// RQ18: All reset sources merge into one internal reset; sys_rst stays separate, int_rst merges undervoltage, command and limp entry.
`timescale 1ns/1ns
module rrs_top #(
   parameter int WAKE_CYCLES = rrs_pkg::WAKE_CYC,
   parameter int NUM_CH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Supply monitors and pins
   input wire logic vbb_low,
   input wire logic vdd_low,
   input wire logic wake_req,
   input wire logic limp_home_input,
   input wire logic control_input_a,
   input wire logic control_input_b,
   // Outputs
   output logic [NUM_CH-1:0] ch_on,
   output logic uv_reset,
   output logic sleep_mode,
   output logic irq
);
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_CYCLES - 1);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic uv;
      rrs_pkg::rrs_mode_t mode;
      logic [WW-1:0] wake_cnt;
      logic [2*NUM_CH-1:0] cfg;
      logic transmission_error_flag;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [31:0] rdata;
      logic [NUM_CH-1:0] ch;
      logic irq;
      logic sleep;
   } rrs_state_t;

   rrs_state_t st_reg;
   rrs_state_t st_next;
   logic vbb_s;
   logic vdd_s;
   logic wake_s;
   logic lh_s;
   logic ina_s;
   logic inb_s;
   logic cmd_rst;
   logic limp_entry;
   logic int_rst;
   logic wr_ok;
   logic [31:0] status_word;
   logic [3:0] ev;

   // Second stage of each synchroniser; only these feed logic.
   assign vbb_s = st_reg.sync2[0];
   assign vdd_s = st_reg.sync2[1];
   assign wake_s = st_reg.sync2[2];
   assign lh_s = st_reg.sync2[3];
   assign ina_s = st_reg.sync2[4];
   assign inb_s = st_reg.sync2[5];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // The pins carry a pull-down, so a floating input settles low and its channels stay off.
      st_next.sync1 = {control_input_b, control_input_a, limp_home_input, wake_req, vdd_low, vbb_low};
      st_next.sync2 = st_reg.sync1;
      // Undervoltage registers the synced comparators, so it holds while a supply is low, three register stages behind the pins.
      st_next.uv = vbb_s | vdd_s; // RQ4 RQ5
      // Writes are refused under undervoltage and in limp home; reads stay served.
      wr_ok = reg_wr && !st_reg.uv && (st_reg.mode != rrs_pkg::MODE_LIMP); // RQ9
      cmd_rst = wr_ok && (reg_addr == rrs_pkg::CMD_OFS) && reg_wdata[rrs_pkg::CMD_RST_BIT]; // RQ6
      limp_entry = lh_s && (st_reg.mode != rrs_pkg::MODE_LIMP); // RQ13
      int_rst = st_reg.uv | cmd_rst | limp_entry; // RQ18
      ev = '0;
      // Mode sequencing.
      case (st_reg.mode)
         rrs_pkg::MODE_SLEEP: begin
            if (wake_s) begin
               st_next.mode = rrs_pkg::MODE_WAKE;
               st_next.wake_cnt = '0;
            end
         end
         rrs_pkg::MODE_WAKE: begin
            // The wake delay is a counter so simulation can shorten it.
            if (st_reg.wake_cnt >= WAKE_LAST) begin // RQ12
               st_next.mode = rrs_pkg::MODE_ACTIVE;
               ev[rrs_pkg::EV_WAKE_BIT] = 1'b1;
            end else begin
               st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
            end
         end
         rrs_pkg::MODE_ACTIVE: begin
            if (wr_ok && (reg_addr == rrs_pkg::CMD_OFS) && reg_wdata[rrs_pkg::CMD_SLEEP_BIT]) begin
               st_next.mode = rrs_pkg::MODE_SLEEP;
            end
         end
         rrs_pkg::MODE_LIMP: begin
            if (!lh_s) begin
               st_next.mode = rrs_pkg::MODE_SLEEP; // RQ15
            end
         end
         default: begin
            st_next.mode = rrs_pkg::MODE_SLEEP;
         end
      endcase
      if (limp_entry) begin
         st_next.mode = rrs_pkg::MODE_LIMP; // RQ13
         ev[rrs_pkg::EV_LIMP_BIT] = 1'b1;
      end
      ev[rrs_pkg::EV_UV_BIT] = st_next.uv & ~st_reg.uv;
      st_next.sleep = (st_next.mode == rrs_pkg::MODE_SLEEP);
      // Software writes.
      if (wr_ok && (reg_addr == rrs_pkg::CFG_OFS)) begin
         st_next.cfg = reg_wdata[2*NUM_CH-1:0];
      end
      if (wr_ok && (reg_addr == rrs_pkg::IRQ_MASK_OFS)) begin
         st_next.irq_mask = reg_wdata[3:0];
      end
      if (wr_ok && (reg_addr == rrs_pkg::STATUS_OFS) && reg_wdata[rrs_pkg::ST_TER_BIT]) begin
         st_next.transmission_error_flag = 1'b0;
      end
      if (wr_ok && (reg_addr == rrs_pkg::IRQ_STAT_OFS)) begin
         st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[3:0];
      end
      // One merged reset restores defaults and marks the error flag.
      if (int_rst) begin
         st_next.cfg = rrs_pkg::CFG_RST; // RQ1 RQ6 RQ7
         st_next.irq_mask = rrs_pkg::IRQ_RST;
         st_next.irq_stat = rrs_pkg::IRQ_RST;
         st_next.transmission_error_flag = 1'b1; // RQ2
         ev[rrs_pkg::EV_RESET_BIT] = 1'b1;
      end
      // Event sets win over a clear in the same cycle.
      st_next.irq_stat = st_next.irq_stat | ev;
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
      // Channel drive.
      st_next.ch = '0;
      if (int_rst) begin
         st_next.ch = '0; // RQ1
      end else if (st_reg.mode == rrs_pkg::MODE_LIMP) begin
         st_next.ch[rrs_pkg::LIMP_CH_A] = ina_s; // RQ14
         st_next.ch[rrs_pkg::LIMP_CH_B] = inb_s; // RQ14
      end else if (st_reg.mode == rrs_pkg::MODE_ACTIVE) begin
         for (int i = 0; i < NUM_CH; i++) begin
            case (st_reg.cfg[2*i +: 2]) // RQ10 RQ17
               rrs_pkg::SEL_OFF: st_next.ch[i] = 1'b0;
               rrs_pkg::SEL_IN_A: st_next.ch[i] = ina_s; // RQ16
               rrs_pkg::SEL_IN_B: st_next.ch[i] = inb_s; // RQ16
               rrs_pkg::SEL_ON: st_next.ch[i] = 1'b1;
               default: st_next.ch[i] = 1'b0;
            endcase
         end
      end
      // Read data.
      status_word = '0;
      status_word[rrs_pkg::ST_TER_BIT] = st_reg.transmission_error_flag;
      status_word[rrs_pkg::ST_LIMP_BIT] = (st_reg.mode == rrs_pkg::MODE_LIMP); // RQ8
      status_word[rrs_pkg::ST_UV_BIT] = st_reg.uv;
      status_word[rrs_pkg::ST_MODE_LSB +: 2] = st_reg.mode;
      status_word[rrs_pkg::ST_CH_LSB +: NUM_CH] = st_reg.ch;
      st_next.rdata = '0;
      if (reg_rd) begin
         if (st_reg.uv) begin
            // Under undervoltage the address is ignored and the diagnostic frame returned.
            st_next.rdata = status_word | 32'h0000_0001; // RQ3
         end else begin
            case (reg_addr)
               rrs_pkg::CFG_OFS: st_next.rdata[2*NUM_CH-1:0] = st_reg.cfg;
               rrs_pkg::STATUS_OFS: st_next.rdata = status_word; // RQ8
               rrs_pkg::IRQ_STAT_OFS: st_next.rdata[3:0] = st_reg.irq_stat;
               rrs_pkg::IRQ_MASK_OFS: st_next.rdata[3:0] = st_reg.irq_mask;
               default: st_next.rdata = '0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= '0; // RQ11
         st_reg.mode <= rrs_pkg::MODE_SLEEP;
         st_reg.sleep <= 1'b1;
         // A power-on is a reset too, so the flag starts set.
         st_reg.transmission_error_flag <= 1'b1; // RQ2
         st_reg.irq_stat <= 4'h1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign ch_on = st_reg.ch;
   assign uv_reset = st_reg.uv;
   assign sleep_mode = st_reg.sleep;
   assign irq = st_reg.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   rst_off_a: assert property (int_rst |=> ch_on == '0) // RQ1
      else $error("channels not off after reset");

   rst_ter_a: assert property (int_rst |=> st_reg.transmission_error_flag && st_reg.cfg == rrs_pkg::CFG_RST) // RQ2
      else $error("error flag or defaults missing after reset");

   uv_read_a: assert property (reg_rd && uv_reset |=> reg_rdata[rrs_pkg::ST_TER_BIT]) // RQ3
      else $error("undervoltage read lacks error flag");

   uv_hold_a: assert property (uv_reset && (vbb_s || vdd_s) |=> uv_reset) // RQ4
      else $error("undervoltage released while supply low");

   uv_delay_a: assert property ((vbb_low || vdd_low) [*3] |=> uv_reset) // RQ5
      else $error("undervoltage reset too late");

   cmd_clear_a: assert property (cmd_rst |=> st_reg.cfg == '0 && st_reg.irq_mask == '0) // RQ6
      else $error("command reset did not clear registers");

   limp_ignore_a: assert property (st_reg.mode == rrs_pkg::MODE_LIMP && reg_wr |=> $stable(st_reg.cfg)) // RQ9
      else $error("write accepted in limp home");

   sel_on_a: assert property (st_reg.mode == rrs_pkg::MODE_ACTIVE && st_reg.cfg[1:0] == rrs_pkg::SEL_ON // RQ10
      && !int_rst |=> ch_on[0])
      else $error("forced on channel is off");

   limp_route_a: assert property (st_reg.mode == rrs_pkg::MODE_LIMP && !int_rst // RQ14
      |=> ch_on[rrs_pkg::LIMP_CH_A] == $past(ina_s))
      else $error("limp channel not following input");

   limp_exit_a: assert property (st_reg.mode == rrs_pkg::MODE_LIMP && !lh_s |=> sleep_mode) // RQ15
      else $error("limp exit did not sleep");

   wake_bound_a: assert property (st_reg.mode == rrs_pkg::MODE_WAKE |-> st_reg.wake_cnt < WW'(WAKE_CYCLES)) // RQ12
      else $error("wake time exceeded");

   uv_defaults_a: assert property (uv_reset |=> st_reg.cfg == rrs_pkg::CFG_RST && ch_on == '0) // RQ1
      else $error("registers not held at defaults under undervoltage");

   uv_release_a: assert property (!vbb_s && !vdd_s |=> !uv_reset) // RQ4
      else $error("undervoltage reset held with supplies good");

   limp_chb_a: assert property (st_reg.mode == rrs_pkg::MODE_LIMP && !int_rst // RQ14
      |=> ch_on[rrs_pkg::LIMP_CH_B] == $past(inb_s))
      else $error("second limp channel not following input");

   limp_rest_a: assert property (st_reg.mode == rrs_pkg::MODE_LIMP // RQ14
      |=> ch_on[rrs_pkg::LIMP_CH_A-1:0] == '0 && ch_on[NUM_CH-1:rrs_pkg::LIMP_CH_B+1] == '0)
      else $error("non limp channel on in limp home");

   sel_ina_a: assert property (st_reg.mode == rrs_pkg::MODE_ACTIVE && st_reg.cfg[3:2] == rrs_pkg::SEL_IN_A // RQ16
      && !int_rst |=> ch_on[1] == $past(ina_s))
      else $error("channel not following input a");

   sel_inb_a: assert property (st_reg.mode == rrs_pkg::MODE_ACTIVE && st_reg.cfg[5:4] == rrs_pkg::SEL_IN_B // RQ16
      && !int_rst |=> ch_on[2] == $past(inb_s))
      else $error("channel not following input b");

   sel_off_a: assert property (st_reg.mode == rrs_pkg::MODE_ACTIVE // RQ10
      && st_reg.cfg[2*NUM_CH-1 -: 2] == rrs_pkg::SEL_OFF |=> !ch_on[NUM_CH-1])
      else $error("forced off channel is on");

   limp_entry_a: assert property (limp_entry |=> st_reg.mode == rrs_pkg::MODE_LIMP && st_reg.transmission_error_flag) // RQ13
      else $error("limp entry did not take effect");

   wake_done_a: assert property (st_reg.mode == rrs_pkg::MODE_WAKE && st_reg.wake_cnt == WAKE_LAST // RQ12
      && !limp_entry |=> st_reg.mode == rrs_pkg::MODE_ACTIVE)
      else $error("wake did not complete in time");
endmodule : rrs_top

// file: tb/rrs_host_model.sv
// Register port master model standing in for the controller on the far side of the block.
`timescale 1ns/1ns
module rrs_host_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // -------------------------------------------------------------
   // Bus cycles
   // -------------------------------------------------------------
   // Released lines show the inverse so that stale values never look valid.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : rrs_host_model

// file: tb/rrs_top_tb.sv
// Self-checking testbench of the relay reset and input select block.
`timescale 1ns/1ns
module rrs_top_tb;
   localparam int WK = 8;
   logic sys_clk, sys_rst, reg_wr, reg_rd, vbb_low, vdd_low, wake_req, limp_home_input;
   logic control_input_a, control_input_b, uv_reset, sleep_mode, irq;
   logic [7:0] reg_addr, ch_on;
   logic [31:0] reg_wdata, reg_rdata, rd;
   int n_fail = 0;
   int n_checks = 0;
   rrs_top #(.WAKE_CYCLES(WK), .NUM_CH(8)) u_rrs_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .vbb_low(vbb_low), .vdd_low(vdd_low), .wake_req(wake_req), .limp_home_input(limp_home_input),
      .control_input_a(control_input_a), .control_input_b(control_input_b), .ch_on(ch_on),
      .uv_reset(uv_reset), .sleep_mode(sleep_mode), .irq(irq));
   rrs_host_model u_rrs_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_rrs_host_model.wr(a, d);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      u_rrs_host_model.rd(a, rd);
   endtask : rdr
   // Codes are spelled out here so that a wrong encoding in the design shows.
   function automatic logic [7:0] exp_ch(input logic [15:0] c, input logic a, input logic b);
      logic [7:0] e;
      for (int i = 0; i < 8; i++) begin
         case (c[2*i+:2])
            2'b00: e[i] = 1'b0;
            2'b01: e[i] = a;
            2'b10: e[i] = b;
            default: e[i] = 1'b1;
         endcase
      end
      return e;
   endfunction : exp_ch
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset;
      chk(ch_on, 8'h00);
      chk(sleep_mode, 1'b1);
      chk(irq, 1'b0);
      rdr(rrs_pkg::STATUS_OFS);
      chk(rd[0], 1'b1);
      rdr(rrs_pkg::CFG_OFS);
      chk(rd, 32'h0000_0000);
      rdr(rrs_pkg::IRQ_STAT_OFS);
      chk(rd, 32'h0000_0001);
      rdr(8'h20);
      chk(rd, 32'h0000_0000);
   endtask : t_reset
   task automatic t_wake;
      @(posedge sys_clk);
      wake_req <= 1'b1;
      cyc(rrs_pkg::SYNC_CYC + WK + 1);
      chk(sleep_mode, 1'b0);
      rdr(rrs_pkg::STATUS_OFS);
      chk(rd[4:3], rrs_pkg::MODE_ACTIVE);
      @(posedge sys_clk);
      wake_req <= 1'b0;
   endtask : t_wake
   task automatic t_irq;
      rdr(rrs_pkg::IRQ_STAT_OFS);
      chk(rd[2], 1'b1);
      wr(rrs_pkg::IRQ_MASK_OFS, 32'h0000_0004);
      cyc(2);
      chk(irq, 1'b1);
      wr(rrs_pkg::IRQ_STAT_OFS, 32'h0000_0004);
      cyc(2);
      chk(irq, 1'b0);
      wr(rrs_pkg::STATUS_OFS, 32'h0000_0001);
      rdr(rrs_pkg::STATUS_OFS);
      chk(rd[0], 1'b0);
   endtask : t_irq
   task automatic t_select;
      wr(rrs_pkg::CFG_OFS, 32'h0000_39E7);
      for (int p = 0; p < 4; p++) begin
         @(posedge sys_clk);
         control_input_a <= p[0];
         control_input_b <= p[1];
         cyc(4);
         chk(ch_on, exp_ch(16'h39E7, p[0], p[1]));
      end
   endtask : t_select
   task automatic t_cmd;
      wr(rrs_pkg::CMD_OFS, 32'h0000_0001);
      cyc(2);
      chk(ch_on, 8'h00);
      rdr(rrs_pkg::CFG_OFS);
      chk(rd, 32'h0000_0000);
      rdr(rrs_pkg::STATUS_OFS);
      chk(rd[0], 1'b1);
      rdr(rrs_pkg::IRQ_STAT_OFS);
      chk(rd[0], 1'b1);
      wr(rrs_pkg::CFG_OFS, 32'h0000_39E4);
      wr(rrs_pkg::STATUS_OFS, 32'h0000_0001);
   endtask : t_cmd
   task automatic t_uv;
      @(posedge sys_clk);
      vbb_low <= 1'b1;
      cyc(rrs_pkg::UV_DELAY_CYC);
      chk(uv_reset, 1'b1);
      chk(ch_on, 8'h00);
      rdr(rrs_pkg::CFG_OFS);
      chk(rd[2:0], 3'h5);
      @(posedge sys_clk);
      vdd_low <= 1'b1;
      vbb_low <= 1'b0;
      cyc(10);
      chk(uv_reset, 1'b1);
      @(posedge sys_clk);
      vdd_low <= 1'b0;
      cyc(4);
      chk(uv_reset, 1'b0);
      rdr(rrs_pkg::STATUS_OFS);
      chk(rd[0], 1'b1);
      rdr(rrs_pkg::CFG_OFS);
      chk(rd, 32'h0000_0000);
      wr(rrs_pkg::CMD_OFS, 32'h0000_0002);
      cyc(1);
      chk(sleep_mode, 1'b1);
   endtask : t_uv
   task automatic t_limp;
      @(posedge sys_clk);
      limp_home_input <= 1'b1;
      control_input_a <= 1'b1;
      control_input_b <= 1'b0;
      cyc(5);
      chk(ch_on, 8'h10);
      rdr(rrs_pkg::STATUS_OFS);
      chk(rd[4:0], {rrs_pkg::MODE_LIMP, 3'h3});
      wr(rrs_pkg::CFG_OFS, 32'h0000_FFFF);
      rdr(rrs_pkg::CFG_OFS);
      chk(rd, 32'h0000_0000);
      rdr(rrs_pkg::IRQ_STAT_OFS);
      chk(rd, 32'h0000_0003);
      @(posedge sys_clk);
      control_input_a <= 1'b0;
      control_input_b <= 1'b1;
      cyc(4);
      chk(ch_on, 8'h20);
      @(posedge sys_clk);
      limp_home_input <= 1'b0;
      cyc(5);
      chk(sleep_mode, 1'b1);
      @(posedge sys_clk);
      limp_home_input <= 1'b1;
      cyc(5);
      chk(sleep_mode, 1'b0);
   endtask : t_limp
   // -------------------------------------------------------------
   // Run control
   // -------------------------------------------------------------
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      sys_rst = 1'b1;
      {vbb_low, vdd_low, wake_req, limp_home_input, control_input_a, control_input_b} = 6'h00;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      cyc(1);
      t_reset();
      t_wake();
      t_irq();
      t_select();
      t_cmd();
      t_uv();
      t_limp();
      end_sim();
   end
   // The full sequence needs well under a thousand cycles.
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
endmodule : rrs_top_tb
